// File: led_breath_pkg.sv
// How it works
// R1: Step fields sit in 4-bit slices by segment.
// R2: Eight 4-bit interval fields, segment 0 lowest.
// R3: Interval value v waits v+1 PWM periods.
// R4: Symmetric index is duty cycle bits 7:5.
// R5: Asymmetric index is falling flag plus bits 7:6.
// R6: Writes go to holding copy, loaded when enabled.
// R7: Reads return active contents, not holding copy.
// R8: Delay field counts source ticks before turn-on.
// R9: Zero delay adds no extra delay.
// R10: Always on or off ignores the delay.
// R11: Software gives each LED a distinct delay.
// R12: Slow clock delays may differ by one.
// R13: In 8-bit mode step s changes by s+1.
// R14: 7-bit mode drops one bit, 6-bit two.
package led_breath_pkg;
  localparam logic [5:0] step_offset = 6'h0C;
  localparam logic [5:0] interval_offset = 6'h10;
  localparam logic [5:0] skew_offset = 6'h14;
  localparam logic [5:0] control_offset = 6'h18;
  localparam logic [5:0] status_offset = 6'h1C;
  localparam logic [31:0] step_reset = 32'h0000_0000;
  localparam logic [31:0] interval_reset = 32'h0000_0000;
  localparam logic [7:0] skew_reset = 8'h00;
  localparam int field_width = 4;
  localparam int segment_count = 8;
  localparam int skew_width = 8;
  // Control register layout.
  localparam int ctl_symmetric_bit = 0;
  localparam int ctl_update_enable_bit = 1;
  localparam int ctl_width_lsb = 2;
  localparam int ctl_steady_bit = 4;
  localparam logic [1:0] res_okay = 2'h0;
  localparam logic [1:0] res_slverr = 2'h2;
  typedef enum logic [1:0] {
    mode_8bit = 2'h0,
    mode_7bit = 2'h1,
    mode_6bit = 2'h2
  } pwm_width_type;
  typedef enum logic [1:0] {
    skew_idle = 2'h0,
    skew_count = 2'h1,
    skew_done = 2'h2
  } skew_state_type;
endpackage : led_breath_pkg

// File: led_breath_update_timing.sv
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module led_breath_update_timing (
  input wire logic aclk, // 250 MHz clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [5:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [5:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic [7:0] duty_cycle, // Current duty cycle from the PWM core.
  input wire logic falling_ramp, // High while the ramp falls.
  input wire logic period_end, // One-cycle pulse at each PWM period end.
  input wire logic skew_start, // Pulse on enable, resume or sync.
  input wire logic source_tick, // One-cycle tick of the selected LED clock.
  output logic [4:0] step_amount, // Duty change per update, 1 to 16.
  output logic update_now, // Pulse, one cycle after a period end whose wait is over: apply step.
  output logic output_allowed // High once the turn-on skew has elapsed.
);
  logic [31:0] step_active, step_hold, interval_active, interval_hold;
  logic [31:0] next_step_active, next_step_hold, next_interval_active, next_interval_hold;
  logic [7:0] skew_delay, next_skew_delay;
  logic [4:0] control, next_control;
  logic aw_seen, w_seen, next_aw_seen, next_w_seen;
  logic [5:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_bvalid, next_rvalid;
  logic next_awready, next_wready, next_arready;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [2:0] segment;
  logic [3:0] step_field, interval_field;
  logic [3:0] wait_count, next_wait_count;
  logic [4:0] next_step_amount;
  logic next_update_now;
  led_breath_pkg::skew_state_type skew_state, next_skew_state;
  logic [7:0] skew_left, next_skew_left;
  logic next_output_allowed;
  logic do_write;
  logic [31:0] merged;

  // Segment index selection and field lookup.
  always_comb begin
    if (control[led_breath_pkg::ctl_symmetric_bit]) begin
      segment = duty_cycle[7:5]; // [R4]
    end else begin
      segment = {falling_ramp, duty_cycle[7:6]}; // [R5]
    end
    step_field = step_active[segment*led_breath_pkg::field_width +: 4]; // [R1]
    interval_field = interval_active[segment*led_breath_pkg::field_width +: 4]; // [R2]
  end

  // Register write path; address and data may arrive in either order.
  always_comb begin
    next_aw_seen = aw_seen;
    next_w_seen = w_seen;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_step_hold = step_hold;
    next_interval_hold = interval_hold;
    next_skew_delay = skew_delay;
    next_control = control;
    merged = 32'h0000_0000;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_seen = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_seen = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    do_write = aw_seen && w_seen && !s_axi_bvalid;
    if (do_write) begin
      next_aw_seen = 1'b0;
      next_w_seen = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = led_breath_pkg::res_okay;
      for (int i = 0; i < 4; i++) begin
        merged[i*8 +: 8] = w_strb[i] ? w_data[i*8 +: 8] : 8'h00;
      end
      // Step and interval writes land in holding copies, which keep unstrobed lanes. [R6]
      case (aw_addr)
        led_breath_pkg::step_offset: begin
          for (int i = 0; i < 4; i++) begin
            if (w_strb[i]) next_step_hold[i*8 +: 8] = merged[i*8 +: 8];
          end
        end
        led_breath_pkg::interval_offset: begin
          for (int i = 0; i < 4; i++) begin
            if (w_strb[i]) next_interval_hold[i*8 +: 8] = merged[i*8 +: 8];
          end
        end
        led_breath_pkg::skew_offset: begin
          if (w_strb[0]) next_skew_delay = merged[7:0];
        end
        led_breath_pkg::control_offset: begin
          if (w_strb[0]) next_control = merged[4:0];
        end
        led_breath_pkg::status_offset: begin
        end
        default: begin
          next_bresp = led_breath_pkg::res_slverr;
        end
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    next_awready = !next_aw_seen && !(s_axi_awvalid && s_axi_awready);
    next_wready = !next_w_seen && !(s_axi_wvalid && s_axi_wready);
  end

  // Active copies follow the holding copies only at a period end when enabled.
  always_comb begin
    next_step_active = step_active;
    next_interval_active = interval_active;
    if (period_end && control[led_breath_pkg::ctl_update_enable_bit]) begin
      next_step_active = step_hold; // [R6]
      next_interval_active = interval_hold; // [R6]
    end
  end

  // Read path returns active copies only.
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = led_breath_pkg::res_okay;
      case (s_axi_araddr)
        led_breath_pkg::step_offset: next_rdata = step_active; // [R7]
        led_breath_pkg::interval_offset: next_rdata = interval_active; // [R7]
        led_breath_pkg::skew_offset: next_rdata = {24'h00_0000, skew_delay};
        led_breath_pkg::control_offset: next_rdata = {27'h000_0000, control};
        led_breath_pkg::status_offset: begin
          next_rdata = {22'h00_0000, output_allowed, segment, wait_count, 2'h0};
        end
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = led_breath_pkg::res_slverr;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    next_arready = !next_rvalid && !(s_axi_arvalid && s_axi_arready);
  end

  // Interval counter and step size; a wait of v+1 periods per update.
  always_comb begin
    next_wait_count = wait_count;
    next_update_now = 1'b0;
    next_step_amount = step_amount;
    case (led_breath_pkg::pwm_width_type'(control[led_breath_pkg::ctl_width_lsb +: 2]))
      led_breath_pkg::mode_7bit: next_step_amount = {2'h0, step_field[3:1]} + 5'h01; // [R14]
      led_breath_pkg::mode_6bit: next_step_amount = {3'h0, step_field[3:2]} + 5'h01; // [R14]
      default: next_step_amount = {1'b0, step_field} + 5'h01; // [R13]
    endcase
    if (period_end) begin
      if (wait_count >= interval_field) begin
        next_wait_count = 4'h0; // [R3]
        next_update_now = 1'b1; // [R3]
      end else begin
        next_wait_count = wait_count + 4'h1;
      end
    end
  end

  // Turn-on skew counter driven by ticks of the selected source.
  always_comb begin
    next_skew_state = skew_state;
    next_skew_left = skew_left;
    next_output_allowed = output_allowed;
    if (control[led_breath_pkg::ctl_steady_bit]) begin
      next_skew_state = led_breath_pkg::skew_done; // [R10]
      next_output_allowed = 1'b1; // [R10]
    end else if (skew_start) begin
      if (skew_delay == 8'h00) begin
        next_skew_state = led_breath_pkg::skew_done; // [R9]
        next_output_allowed = 1'b1; // [R9]
      end else begin
        next_skew_state = led_breath_pkg::skew_count; // [R8]
        next_skew_left = skew_delay;
        next_output_allowed = 1'b0;
      end
    end else begin
      case (skew_state)
        led_breath_pkg::skew_idle: next_output_allowed = 1'b0;
        led_breath_pkg::skew_count: begin
          if (source_tick) begin
            next_skew_left = skew_left - 8'h01; // [R8]
            if (skew_left == 8'h01) begin
              next_skew_state = led_breath_pkg::skew_done;
              next_output_allowed = 1'b1;
            end
          end
        end
        led_breath_pkg::skew_done: next_output_allowed = 1'b1;
        default: next_skew_state = led_breath_pkg::skew_idle;
      endcase
    end
  end

  // All state registers; handshake readies come from flip-flops too.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_active <= led_breath_pkg::step_reset;
      step_hold <= led_breath_pkg::step_reset;
      interval_active <= led_breath_pkg::interval_reset;
      interval_hold <= led_breath_pkg::interval_reset;
      skew_delay <= led_breath_pkg::skew_reset;
      control <= 5'h00;
      aw_seen <= 1'b0;
      w_seen <= 1'b0;
      aw_addr <= 6'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
      wait_count <= 4'h0;
      update_now <= 1'b0;
      step_amount <= 5'h01;
      skew_state <= led_breath_pkg::skew_idle;
      skew_left <= 8'h00;
      output_allowed <= 1'b0;
    end else begin
      step_active <= next_step_active;
      step_hold <= next_step_hold;
      interval_active <= next_interval_active;
      interval_hold <= next_interval_hold;
      skew_delay <= next_skew_delay;
      control <= next_control;
      aw_seen <= next_aw_seen;
      w_seen <= next_w_seen;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      wait_count <= next_wait_count;
      update_now <= next_update_now;
      step_amount <= next_step_amount;
      skew_state <= next_skew_state;
      skew_left <= next_skew_left;
      output_allowed <= next_output_allowed;
    end
  end

  // Checks on the update and skew behaviour.
  property p_hold_load;
    @(posedge aclk) disable iff (!aresetn)
      period_end && control[1] |=> interval_active == $past(interval_hold);
  endproperty
  a_hold_load: assert property (p_hold_load) else $error("holding copy not loaded"); // [R6]
  property p_no_load;
    @(posedge aclk) disable iff (!aresetn)
      !(period_end && control[1]) |=> $stable(interval_active) && $stable(step_active);
  endproperty
  a_no_load: assert property (p_no_load) else $error("active copy changed"); // [R6]
  property p_zero_wait;
    @(posedge aclk) disable iff (!aresetn)
      period_end && interval_field == 4'h0 |=> update_now;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("zero interval did not update"); // [R3]
  property p_no_update;
    @(posedge aclk) disable iff (!aresetn) !period_end |=> !update_now;
  endproperty
  a_no_update: assert property (p_no_update) else $error("update off period end"); // [R3]
  property p_sym;
    @(posedge aclk) disable iff (!aresetn) control[0] |-> segment == duty_cycle[7:5];
  endproperty
  a_sym: assert property (p_sym) else $error("symmetric index wrong"); // [R4]
  property p_asym;
    @(posedge aclk) disable iff (!aresetn)
      !control[0] |-> segment == {falling_ramp, duty_cycle[7:6]};
  endproperty
  a_asym: assert property (p_asym) else $error("asymmetric index wrong"); // [R5]
  property p_step8;
    @(posedge aclk) disable iff (!aresetn)
      control[3:2] == 2'h0 |=> step_amount == {1'b0, $past(step_field)} + 5'h01;
  endproperty
  a_step8: assert property (p_step8) else $error("8-bit step wrong"); // [R13]
  property p_step6;
    @(posedge aclk) disable iff (!aresetn)
      control[3:2] == 2'h2 |=> step_amount <= 5'h04;
  endproperty
  a_step6: assert property (p_step6) else $error("6-bit step too large"); // [R14]
  property p_zero_skew;
    @(posedge aclk) disable iff (!aresetn) skew_start && skew_delay == 8'h00 |=> output_allowed;
  endproperty
  a_zero_skew: assert property (p_zero_skew) else $error("zero delay not immediate"); // [R9]
  property p_skew_hold;
    @(posedge aclk) disable iff (!aresetn)
      skew_start && skew_delay != 8'h00 && !control[4] |=> !output_allowed;
  endproperty
  a_skew_hold: assert property (p_skew_hold) else $error("skew not applied"); // [R8]
  property p_steady;
    @(posedge aclk) disable iff (!aresetn) control[4] |=> output_allowed;
  endproperty
  a_steady: assert property (p_steady) else $error("steady mode delayed"); // [R10]
  c_update: cover property (@(posedge aclk) update_now);
  c_skew_done: cover property (@(posedge aclk) skew_state == led_breath_pkg::skew_count
    ##[1:300] output_allowed);
  c_write: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
  c_load: cover property (@(posedge aclk) period_end && control[1]);
endmodule : led_breath_update_timing
`default_nettype wire

// File: led_pwm_partner.sv
`timescale 1ns/1ns
`default_nettype none
module led_pwm_partner #(
  parameter int period_len = 6, // Clock cycles per PWM period.
  parameter int tick_len = 3 // Clock cycles per LED source tick.
) (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic run_periods, // The PWM counter runs.
  input wire logic run_ticks, // The LED clock source runs.
  output logic period_end, // Pulse at each PWM period end.
  output logic source_tick // Pulse at each LED source tick.
);
  logic [7:0] pcount, tcount, next_pcount, next_tcount;
  logic next_period_end, next_source_tick;
  // A stopped source holds its phase, so a tick can land on the first edge after a restart.
  always_comb begin
    next_pcount = pcount;
    next_tcount = tcount;
    next_period_end = run_periods && (pcount == 8'(period_len - 1));
    next_source_tick = run_ticks && (tcount == 8'(tick_len - 1));
    if (run_periods) next_pcount = next_period_end ? 8'h00 : pcount + 8'h01;
    if (run_ticks) next_tcount = next_source_tick ? 8'h00 : tcount + 8'h01;
  end
  // Registers only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pcount <= 8'h00;
      tcount <= 8'h00;
      period_end <= 1'b0;
      source_tick <= 1'b0;
    end else begin
      pcount <= next_pcount;
      tcount <= next_tcount;
      period_end <= next_period_end;
      source_tick <= next_source_tick;
    end
  end
endmodule : led_pwm_partner
`default_nettype wire

// File: led_breath_update_timing_tb.sv
`timescale 1ns/1ns
`default_nettype none
module led_breath_update_timing_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, skew_start = 1'b0;
  logic falling_ramp = 1'b0, run_periods = 1'b0, run_ticks = 1'b0;
  logic [7:0] duty_cycle = 8'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic update_now, output_allowed, period_end, source_tick;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd_val;
  logic [4:0] step_amount;
  int errors = 0, total_checks = 0, pe_cnt = 0, last_gap = 0;
  // Rows hold control, duty, falling flag and the expected step.
  logic [31:0] step_rows [12] = '{32'h0300_0010, 32'h0320_0006, 32'h035F_000B, 32'h037F_0004,
    32'h0240_0006, 32'h0280_000B, 32'h0200_0108, 32'h0700_0008, 32'h0720_0003,
    32'h0B00_0004, 32'h0B5F_0003, 32'h0380_0108};
  logic [15:0] gap_rows [3] = '{16'h0004, 16'hE010, 16'h4001};
  logic [23:0] skew_rows [4] = '{24'h03_0505, 24'h03_0606, 24'h03_0000, 24'h13_0500};

  always #2 aclk = ~aclk;

  led_breath_update_timing i_led_breath_update_timing (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .duty_cycle, .falling_ramp, .period_end,
    .skew_start, .source_tick, .step_amount, .update_now, .output_allowed
  );

  led_pwm_partner i_led_pwm_partner (
    .aclk, .aresetn, .run_periods, .run_ticks, .period_end, .source_tick
  );

  // Counts period ends between update pulses; no pulse overlaps a period end here.
  always @(posedge aclk) begin
    if (update_now) begin
      last_gap <= pe_cnt;
      pe_cnt <= 0;
    end else if (period_end) begin
      pe_cnt <= pe_cnt + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Address and data go out together; each is dropped on the edge that takes it.
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_val = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // The run is cut short if a handshake never comes back.
  initial begin
    #200000;
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end

  initial begin
    int n;
    int cyc;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    run_periods <= 1'b1;
    @(posedge aclk);
    chk(step_amount, 32'h1, "reset step");
    rd(led_breath_pkg::step_offset);
    chk(rd_val, led_breath_pkg::step_reset, "step reset");
    rd(led_breath_pkg::interval_offset);
    chk(rd_val, led_breath_pkg::interval_reset, "interval reset");
    // With updates disabled, writes stay pending through several period ends.
    wr(led_breath_pkg::step_offset, 32'h0007_3A5F);
    wr(led_breath_pkg::interval_offset, 32'hF000_0003);
    repeat (20) @(posedge aclk);
    rd(led_breath_pkg::step_offset);
    chk(rd_val, 32'h0, "step held back");
    rd(led_breath_pkg::interval_offset);
    chk(rd_val, 32'h0, "interval held back");
    wr(led_breath_pkg::control_offset, 32'h3);
    repeat (20) @(posedge aclk);
    rd(led_breath_pkg::step_offset);
    chk(rd_val, 32'h0007_3A5F, "step loaded");
    rd(led_breath_pkg::interval_offset);
    chk(rd_val, 32'hF000_0003, "interval loaded");
    // Segment selection and step scaling across shapes and widths.
    foreach (step_rows[i]) begin
      wr(led_breath_pkg::control_offset, {24'h0, step_rows[i][31:24]});
      duty_cycle <= step_rows[i][23:16];
      falling_ramp <= step_rows[i][8];
      repeat (3) @(posedge aclk);
      chk(step_amount, step_rows[i][4:0], "step size");
    end
    // Interval fields of segments 0, 7 and 2; the first two gaps after a change are skipped.
    wr(led_breath_pkg::control_offset, 32'h3);
    falling_ramp <= 1'b0;
    foreach (gap_rows[i]) begin
      duty_cycle <= gap_rows[i][15:8];
      repeat (3) begin
        cyc = 0;
        do begin
          @(posedge aclk);
          cyc++;
        end while (!update_now && cyc < 200);
        chk(update_now, 32'h1, "update pulse");
      end
      @(posedge aclk);
      chk(last_gap, gap_rows[i][7:0], "update gap");
    end
    // Turn-on skew: distinct delays one count apart, zero, and steady mode.
    foreach (skew_rows[i]) begin
      wr(led_breath_pkg::control_offset, {24'h0, skew_rows[i][23:16]});
      wr(led_breath_pkg::skew_offset, {24'h0, skew_rows[i][15:8]});
      @(posedge aclk);
      skew_start <= 1'b1;
      @(posedge aclk);
      skew_start <= 1'b0;
      run_ticks <= 1'b1;
      n = 0;
      cyc = 0;
      do begin
        @(posedge aclk);
        if (!output_allowed && source_tick) n++;
        cyc++;
      end while (!output_allowed && cyc < 300);
      run_ticks <= 1'b0;
      chk(n, skew_rows[i][7:0], "skew ticks");
      chk(output_allowed, 32'h1, "skew done");
    end
    // Unmapped offsets are refused and leave nothing behind.
    wr(6'h00, 32'hFFFF_FFFF);
    chk(resp, led_breath_pkg::res_slverr, "unmapped write");
    rd(6'h00);
    chk({resp, rd_val}, {led_breath_pkg::res_slverr, 32'h0}, "unmapped read");
    // A second reset in mid-run clears the loaded tables again.
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(step_amount, 32'h1, "second reset step");
    rd(led_breath_pkg::step_offset);
    chk(rd_val, led_breath_pkg::step_reset, "second reset table");
    test_done();
  end
endmodule : led_breath_update_timing_tb
`default_nettype wire
